// file: core/mpw_port.v
`timescale 1ns/100ps
`default_nettype none
`include "mpw_defs.vh"

// ----------------------------------------
// Request buffer toward the memory cycle
// ----------------------------------------
module mpw_fifo #(
    parameter W     = `MPW_ENTRY_W,
    parameter DEPTH = `MPW_FIFO_DEPTH,
    parameter AW    = `MPW_FIFO_AW
) (
    input  wire         clk,
    input  wire         reset,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output reg          out_valid,
    input  wire         out_ready,
    output reg  [W-1:0] out_data
);
    reg  [W-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0] wr_ptr;
    reg  [AW-1:0] rd_ptr;
    reg  [AW:0]   count;
    wire          push;
    wire          pull;

    // Full is honest: the array alone holds DEPTH words
    assign in_ready = (count != DEPTH[AW:0]);
    assign push     = in_valid && in_ready;
    // Refill the output stage when it is empty or being taken
    assign pull     = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    // Storage array, written without reset
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers, fill level and registered head
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {W{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pull) begin
                rd_ptr   <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
            end
            if (push && !pull) begin
                count <= count + 1'b1;
            end else if (pull && !push) begin
                count <= count - 1'b1;
            end
            if (pull) begin
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// How it works
// - Latch 16 or 32 bits plus parity
// - Write acknowledge right after latching data
// - Read full word, return port width
// - One 29-bit word address input
// - Respond only inside programmed windows
// - Four 4K single-bit RAMs, 128K granules
// - Bits 17-28 index, 29-30 pick RAM
// - Address bit 31 never decoded
// - Load word: bits 1-12 entry, four values
// - Bits 13,14,15,0 to RAMs 0-3
// - Table survives reset, no clearing
// - Second variant: local and global tables
// - Bits 17-30 (wide) or 16-29 (narrow) index both tables
// - Load word: bits 1-14 entry, two values
// - 128K granule wide, 64K narrow
// - Bank address adds base to upper half
module mpw_port (
    input  wire        mclk,
    input  wire        reset,
    input  wire        variant_lg,
    input  wire        wide_port,
    input  wire        test_mode,
    input  wire [15:0] base_value,
    input  wire        load_valid,
    input  wire [15:0] load_word,
    input  wire        req_valid,
    input  wire        req_write,
    input  wire [30:2] chan_addr,
    input  wire        chan_half,
    input  wire [31:0] wr_data,
    input  wire [3:0]  wr_par,
    output reg         req_ready,
    output reg         addr_ack,
    output reg         data_ack,
    output reg  [31:0] rd_data,
    output reg  [3:0]  rd_par,
    output reg         win_miss,
    output wire        mem_valid,
    input  wire        mem_ready,
    output wire        mem_write,
    output wire        mem_global,
    output wire [1:0]  mem_half_en,
    output wire [29:0] mem_addr,
    output wire [31:0] mem_wdata,
    output wire [3:0]  mem_wpar,
    input  wire        mem_rvalid,
    input  wire [31:0] mem_rdata,
    input  wire [3:0]  mem_rpar
);
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_LOOK = 2'h1;
    localparam [1:0] ST_PUSH = 2'h2;
    localparam [1:0] ST_READ = 2'h3;

    reg  [1:0]  state;
    reg  [1:0]  next_state;

    // Latched request
    reg         lat_write;
    reg  [30:2] lat_addr;
    reg         lat_half;
    reg         lat_wide;
    reg  [31:0] lat_data;
    reg  [3:0]  lat_par;
    reg         lat_glb;

    // ----------------------------------------
    // Window look-up tables
    // ----------------------------------------
    wire [13:0] look_idx;
    wire [13:0] load_idx;
    wire [3:0]  v1_bits;
    wire [3:0]  loc_q;
    wire [3:0]  glb_q;
    reg  [1:0]  look_sel;
    wire        hit_loc;
    wire        hit_glb;
    wire        win_hit;

    // Narrow port on the split tables looks one bit lower: 64K granule
    assign look_idx = (variant_lg && !wide_port) ? chan_addr[29:16]
                                                 : chan_addr[30:17];
    assign load_idx = variant_lg ? load_word[14:1]
                                 : {2'h0, load_word[12:1]};
    assign v1_bits  = {load_word[`MPW_V1_BIT_RAM3], load_word[`MPW_V1_BIT_RAM2],
                       load_word[`MPW_V1_BIT_RAM1], load_word[`MPW_V1_BIT_RAM0]};

    // Loads are honoured only while the controller holds test mode
    genvar k;
    generate
        for (k = 0; k < `MPW_LUT_RAMS; k = k + 1) begin : g_lut
            // No reset: contents ride through like a standby-powered RAM
            reg  lut_loc [0:`MPW_LUT_DEPTH-1];
            reg  lut_glb [0:`MPW_LUT_DEPTH-1];
            reg  q_loc;
            reg  q_glb;
            wire wr_v1;
            wire wr_v2;

            assign wr_v1 = load_valid && test_mode && !variant_lg;
            assign wr_v2 = load_valid && test_mode && variant_lg
                           && (load_idx[13:12] == k);

            // Table write, and registered read of this RAM
            always @(posedge mclk) begin
                if (wr_v1) begin
                    lut_loc[load_idx[11:0]] <= v1_bits[k];
                end else if (wr_v2) begin
                    lut_loc[load_idx[11:0]] <= load_word[`MPW_V2_BIT_LOC];
                end
                if (wr_v2) begin
                    lut_glb[load_idx[11:0]] <= load_word[`MPW_V2_BIT_GLB];
                end
                q_loc <= lut_loc[look_idx[11:0]];
                q_glb <= lut_glb[look_idx[11:0]];
            end
            assign loc_q[k] = q_loc;
            assign glb_q[k] = q_glb;
        end
    endgenerate

    // Remember which RAM was picked, then hold the global flag of the take:
    // the source may move its address once the request is taken
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            look_sel <= 2'h0;
            lat_glb  <= 1'b0;
        end else if (state == ST_IDLE) begin
            look_sel <= look_idx[13:12];
        end else if (state == ST_LOOK) begin
            lat_glb <= hit_glb;
        end
    end

    // Global table only exists on the split-table variant
    assign hit_loc = loc_q[look_sel];
    assign hit_glb = variant_lg && glb_q[look_sel];
    assign win_hit = hit_loc || hit_glb;

    // ----------------------------------------
    // Bank address and buffer entry
    // ----------------------------------------
    wire [31:0] byte_addr;
    wire [15:0] bank_upper;
    wire [29:0] bank_addr;
    wire [1:0]  half_en;
    wire [69:0] entry;
    wire        fifo_in_ready;
    wire [69:0] fifo_out;

    assign byte_addr  = {1'b0, lat_addr, 2'h0};
    // Only the upper half is relocated; the low 64K offset passes
    assign bank_upper = byte_addr[31:16] + base_value;
    assign bank_addr  = {bank_upper, byte_addr[15:2]};
    assign half_en    = lat_wide ? 2'h3 : (lat_half ? 2'h2 : 2'h1);
    assign entry      = {lat_write, lat_glb, half_en, bank_addr,
                         lat_data, lat_par};

    // Buffer between channel and memory cycle
    mpw_fifo #(
        .W     (`MPW_ENTRY_W),
        .DEPTH (`MPW_FIFO_DEPTH),
        .AW    (`MPW_FIFO_AW)
    ) mpw_fifo_inst (
        .clk       (mclk),
        .reset     (reset),
        .in_valid  (state == ST_PUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (entry),
        .out_valid (mem_valid),
        .out_ready (mem_ready),
        .out_data  (fifo_out)
    );

    assign mem_write   = fifo_out[69];
    assign mem_global  = fifo_out[68];
    assign mem_half_en = fifo_out[67:66];
    assign mem_addr    = fifo_out[65:36];
    assign mem_wdata   = fifo_out[35:4];
    assign mem_wpar    = fifo_out[3:0];

    // ----------------------------------------
    // Request sequencer
    // ----------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req_valid && !test_mode) begin
                    next_state = ST_LOOK;
                end
            end
            ST_LOOK: begin
                // A miss drops the request without any answer
                next_state = win_hit ? ST_PUSH : ST_IDLE;
            end
            ST_PUSH: begin
                if (fifo_in_ready) begin
                    next_state = lat_write ? ST_IDLE : ST_READ;
                end
            end
            ST_READ: begin
                if (mem_rvalid) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Capture the request; write data is held in the buffer entry
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            lat_write <= 1'b0;
            lat_addr  <= 29'h0;
            lat_half  <= 1'b0;
            lat_wide  <= 1'b0;
            lat_data  <= 32'h0;
            lat_par   <= 4'h0;
        end else if (state == ST_IDLE && req_valid && !test_mode) begin
            lat_write <= req_write;
            lat_addr  <= chan_addr;
            lat_half  <= chan_half;
            lat_wide  <= wide_port;
            // Narrow write: 16 bits plus 2 parity on the chosen half
            if (wide_port) begin
                lat_data <= wr_data;
                lat_par  <= wr_par;
            end else begin
                lat_data <= {wr_data[15:0], wr_data[15:0]};
                lat_par  <= {wr_par[1:0], wr_par[1:0]};
            end
        end
    end

    // State register and registered channel answers
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            state     <= ST_IDLE;
            req_ready <= 1'b0;
            addr_ack  <= 1'b0;
            data_ack  <= 1'b0;
            rd_data   <= 32'h0;
            rd_par    <= 4'h0;
            win_miss  <= 1'b0;
        end else begin
            state     <= next_state;
            req_ready <= (next_state == ST_IDLE) && !test_mode;
            addr_ack  <= (state == ST_PUSH) && fifo_in_ready;
            // Writes do not wait for the memory cycle
            data_ack  <= ((state == ST_PUSH) && fifo_in_ready && lat_write)
                         || ((state == ST_READ) && mem_rvalid);
            win_miss  <= (state == ST_LOOK) && !win_hit;
            if (state == ST_READ && mem_rvalid) begin
                if (lat_wide) begin
                    rd_data <= mem_rdata;
                    rd_par  <= mem_rpar;
                end else if (lat_half) begin
                    rd_data <= {16'h0, mem_rdata[31:16]};
                    rd_par  <= {2'h0, mem_rpar[3:2]};
                end else begin
                    rd_data <= {16'h0, mem_rdata[15:0]};
                    rd_par  <= {2'h0, mem_rpar[1:0]};
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: core/mpw_defs.vh
`ifndef MPW_DEFS_VH
`define MPW_DEFS_VH

// ----------------------------------------
// Channel and data widths
// ----------------------------------------
`define MPW_HALF_W      16
`define MPW_WORD_W      32
`define MPW_PAR_W       4
`define MPW_BASE_W      16
`define MPW_BANK_AW     30

// ----------------------------------------
// Window look-up geometry
// ----------------------------------------
`define MPW_LUT_RAMS    4
`define MPW_LUT_DEPTH   4096
`define MPW_LUT_IDX_W   12
`define MPW_LUT_SEL_W   2

// Four-RAM load word: value bit for each RAM
`define MPW_V1_BIT_RAM0 13
`define MPW_V1_BIT_RAM1 14
`define MPW_V1_BIT_RAM2 15
`define MPW_V1_BIT_RAM3 0

// Local/global load word: value bits
`define MPW_V2_BIT_LOC  0
`define MPW_V2_BIT_GLB  15

// ----------------------------------------
// Request buffer
// ----------------------------------------
`define MPW_FIFO_DEPTH  16
`define MPW_FIFO_AW     4
`define MPW_ENTRY_W     70

`endif

// file: dv/mpw_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port protocol checker
// ----------------------------------------
module mpw_port_properties (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        test_mode,
    input wire logic        wide_port,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_ready,
    input wire logic        addr_ack,
    input wire logic        data_ack,
    input wire logic [31:0] rd_data,
    input wire logic [3:0]  rd_par,
    input wire logic        win_miss,
    input wire logic        mem_valid,
    input wire logic        mem_ready,
    input wire logic [1:0]  mem_half_en,
    input wire logic [29:0] mem_addr,
    input wire logic [31:0] mem_rdata,
    input wire logic [3:0]  mem_rpar
);
    wire take = req_valid && req_ready && !test_mode;
    wire rd_ret = data_ack && !addr_ack;
    // Width of the request in flight; the source may switch width as the answer lands
    logic tk_wide;
    always @(posedge mclk) if (take) tk_wide <= wide_port;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // A miss answers nothing and follows its take closely
    a_miss_no_ack: assert property (win_miss |-> !addr_ack && !data_ack)
        else $error("miss acknowledged");
    a_miss_timing: assert property (win_miss |-> $past(take, 2) || $past(take, 3))
        else $error("miss without request");
    // Every taken request is answered in bounded time
    a_write_acked: assert property (take && req_write |-> ##[2:200] (win_miss || addr_ack && data_ack))
        else $error("write not acknowledged");
    a_read_answer: assert property (take && !req_write |-> ##[2:200] (win_miss || data_ack))
        else $error("read not answered");
    a_busy_after: assert property (take |=> !req_ready)
        else $error("ready during request");
    a_test_blocks: assert property ($past(test_mode) |-> !req_ready)
        else $error("ready in test mode");
    // Read return carries the memory word at the port width
    a_wide_return: assert property (rd_ret && tk_wide |-> {rd_par, rd_data} == $past({mem_rpar, mem_rdata}))
        else $error("wide read data wrong");
    a_narrow_return: assert property (rd_ret && !tk_wide |-> rd_data[31:16] == 16'h0 && rd_par[3:2] == 2'h0)
        else $error("narrow upper half not zero");
    // Buffer head is marked by width and held while stalled
    a_half_enable: assert property (mem_valid |-> (wide_port ? mem_half_en == 2'h3 : $onehot(mem_half_en)))
        else $error("half enable wrong");
    a_head_holds: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
        else $error("head changed while stalled");
    c_write_hit: cover property (take && req_write ##3 addr_ack);
    c_miss: cover property (win_miss);
    c_read_return: cover property (rd_ret);
    c_stall: cover property (mem_valid && !mem_ready [*4]);
endmodule

bind mpw_port mpw_port_properties mpw_port_properties_inst (.mclk, .reset, .test_mode, .wide_port, .req_valid,
    .req_write, .req_ready, .addr_ack, .data_ack, .rd_data, .rd_par, .win_miss, .mem_valid, .mem_ready,
    .mem_half_en, .mem_addr, .mem_rdata, .mem_rpar);
`default_nettype wire

// file: dv/mpw_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Bank memory behind the port
// ----------------------------------------
module mpw_mem_model (
    input  wire logic        mclk,
    input  wire logic [1:0]  pace,
    input  wire logic        mem_valid,
    output logic             mem_ready,
    input  wire logic        mem_write,
    input  wire logic [1:0]  mem_half_en,
    input  wire logic [29:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [3:0]  mem_wpar,
    output logic             mem_rvalid,
    output logic [31:0]      mem_rdata,
    output logic [3:0]       mem_rpar
);
    logic [35:0] mem [64];
    logic [35:0] w;
    logic        tog = 1'b0;
    // Pace 0 takes every cycle, 1 every other, 2 stalls; stale data is inverted so nobody relies on it
    always @(posedge mclk) begin
        tog <= !tog;
        mem_ready <= pace == 2'h0 || pace == 2'h1 && tog;
        mem_rvalid <= 1'b0;
        {mem_rpar, mem_rdata} <= ~{mem_rpar, mem_rdata};
        w = mem[mem_addr[5:0]];
        if (mem_valid && mem_ready && !mem_write) begin
            mem_rvalid <= 1'b1;
            {mem_rpar, mem_rdata} <= w;
        end
        if (mem_half_en[0]) {w[33:32], w[15:0]} = {mem_wpar[1:0], mem_wdata[15:0]};
        if (mem_half_en[1]) {w[35:34], w[31:16]} = {mem_wpar[3:2], mem_wdata[31:16]};
        if (mem_valid && mem_ready && mem_write) mem[mem_addr[5:0]] <= w;
    end
endmodule
`default_nettype wire

// file: dv/test_mpw_port.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port testbench
// ----------------------------------------
module test_mpw_port;
    logic        mclk = 1'b0, reset = 1'b1, variant_lg = 1'b0, wide_port = 1'b1, test_mode = 1'b0;
    logic        load_valid = 1'b0, req_valid = 1'b0, req_write = 1'b0, chan_half = 1'b0;
    logic        hit, dack, miss, done, mglob;
    logic [15:0] base_value = 16'h0003, load_word = 16'h0;
    logic [30:2] chan_addr = 29'h0;
    logic [31:0] wr_data = 32'h0;
    logic [3:0]  wr_par = 4'h0;
    logic [1:0]  pace = 2'h0;
    logic [35:0] rdv;
    logic [29:0] madr;
    int          err_count = 0, check_count = 0;
    wire         req_ready, addr_ack, data_ack, win_miss, mem_valid, mem_ready, mem_write, mem_global, mem_rvalid;
    wire [1:0]   mem_half_en;
    wire [29:0]  mem_addr;
    wire [31:0]  rd_data, mem_wdata, mem_rdata;
    wire [3:0]   rd_par, mem_wpar, mem_rpar;

    mpw_port mpw_port_inst (.mclk, .reset, .variant_lg, .wide_port, .test_mode, .base_value, .load_valid,
        .load_word, .req_valid, .req_write, .chan_addr, .chan_half, .wr_data, .wr_par, .req_ready, .addr_ack,
        .data_ack, .rd_data, .rd_par, .win_miss, .mem_valid, .mem_ready, .mem_write, .mem_global,
        .mem_half_en, .mem_addr, .mem_wdata, .mem_wpar, .mem_rvalid, .mem_rdata, .mem_rpar);
    mpw_mem_model mpw_mem_model_inst (.mclk, .pace, .mem_valid, .mem_ready, .mem_write, .mem_half_en,
        .mem_addr, .mem_wdata, .mem_wpar, .mem_rvalid, .mem_rdata, .mem_rpar);

    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    // Last head the memory took, for address and local/global checks
    always @(posedge mclk) if (mem_valid && mem_ready) {madr, mglob} <= {mem_addr, mem_global};

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Loads stream back to back with the strobe held up; a request offered meanwhile is refused
    task automatic tables(input logic lg, input logic [15:0] w [4]);
        variant_lg = lg;
        test_mode = 1'b1;
        req_valid = 1'b1;
        tick;
        chk("ready in test", 1'b0, req_ready);
        foreach (w[i]) begin
            load_valid = 1'b1;
            load_word = w[i];
            tick;
            chk("refused in test", 3'h0, {addr_ack, data_ack, win_miss});
        end
        {load_valid, req_valid, test_mode} = 3'h0;
        tick;
    endtask

    // One request; a short lim is allowed to run out when the buffer is full
    task automatic req(input logic wr, input logic [30:2] a, input logic hf, input logic [35:0] d, input int lim);
        {req_write, chan_addr, chan_half, wr_par, wr_data} = {wr, a, hf, d};
        {hit, dack, miss, done} = 4'h0;
        req_valid = 1'b1;
        tick;
        req_valid = 1'b0;
        for (int k = 0; k < lim && !done; k++) begin
            tick;
            hit |= addr_ack === 1'b1;
            miss |= win_miss === 1'b1;
            if (data_ack === 1'b1) begin
                dack = 1'b1;
                rdv = {rd_par, rd_data};
            end
            done = req_ready === 1'b1;
        end
        if (!done && lim > 50) begin
            chk("request done", 1'b1, done);
            give_verdict;
        end
    endtask

    // Head appears one cycle after the write ack, then the buffer must empty
    task automatic drain;
        repeat (2) tick;
        for (int k = 0; k < 60 && mem_valid !== 1'b0; k++) tick;
        chk("buffer empty", 1'b0, mem_valid);
        if (mem_valid !== 1'b0) give_verdict;
    endtask

    task automatic t_four_ram;
        logic [15:0] w [4];
        logic        e;
        w = '{16'h400b, 16'h000c, 16'he00f, 16'h2010};
        tables(1'b0, w);
        for (int j = 0; j < 4; j++) begin
            for (int s = 0; s < 4; s++) begin
                e = (s == 3) ? w[j][0] : w[j][13 + s];
                req(1'b1, {s[1:0], w[j][12:1], 15'h0}, 1'b0, 36'h0, 200);
                chk("window hit", e, hit);
                chk("write ack", e, dack);
                chk("window miss", !e, miss);
            end
        end
        $display("t_four_ram done");
    endtask

    task automatic t_data;
        logic [30:2] a;
        a = {2'h2, 12'h007, 15'h1234};
        pace = 2'h1;
        req(1'b1, a, 1'b0, 36'h5a1b2c3d4, 200);
        drain;
        chk("bank address", {{1'b0, a[30:16]} + base_value, a[15:2]}, madr);
        req(1'b0, a, 1'b0, 36'h0, 200);
        chk("wide read", 36'h5a1b2c3d4, rdv);
        wide_port = 1'b0;
        req(1'b1, a, 1'b0, 36'h10000beef, 200);
        req(1'b1, a, 1'b1, 36'h200001234, 200);
        req(1'b0, a, 1'b0, 36'h0, 200);
        chk("narrow low", 36'h10000beef, rdv);
        req(1'b0, a, 1'b1, 36'h0, 200);
        chk("narrow high", 36'h200001234, rdv);
        wide_port = 1'b1;
        req(1'b0, a, 1'b0, 36'h0, 200);
        chk("word halves", 36'h91234beef, rdv);
        pace = 2'h0;
        $display("t_data done");
    endtask

    task automatic t_lg;
        logic [13:0] x;
        tables(1'b1, '{16'h0043, 16'h8044, 16'h0046, 16'h8049});
        for (int n = 0; n < 2; n++) begin
            wide_port = !n[0];
            for (int j = 0; j < 4; j++) begin
                x = 14'h21 + 14'(j);
                req(1'b1, n ? {1'b0, x, 14'h0} : {x, 15'h0}, 1'b0, 36'h0, 200);
                chk("window hit", j != 2, hit);
                chk("window miss", j == 2, miss);
                if (j != 2) drain;
                if (j != 2) chk("global", j[0], mglob);
            end
        end
        $display("t_lg done");
    endtask

    // Tables survive a reset; stalled memory lets the buffer fill until it refuses
    task automatic t_fill;
        int n;
        {variant_lg, wide_port, reset} = 3'h3;
        repeat (2) tick;
        reset = 1'b0;
        tick;
        pace = 2'h2;
        for (n = 0; n < 20; n++) begin
            req(1'b1, {2'h0, 12'h007, 15'(n)}, 1'b0, {4'h3, 32'(n)}, 20);
            if (n == 0) chk("table kept", 1'b1, hit);
            if (!done) break;
        end
        // Sixteen buffered words plus the stalled head register
        chk("buffer fills", 36'd17, 36'(n));
        pace = 2'h0;
        for (int k = 0; k < 100 && !done; k++) begin
            tick;
            done = req_ready === 1'b1;
        end
        chk("stalled write done", 1'b1, done);
        if (!done) give_verdict;
        drain;
        req(1'b0, {2'h0, 12'h007, 15'h0}, 1'b0, 36'h0, 200);
        chk("first fill word", 36'h300000000, rdv);
        $display("t_fill done");
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        #1 reset = 1'b0;
        tick;
        t_four_ram;
        t_data;
        t_lg;
        t_fill;
        give_verdict;
    end
endmodule
`default_nettype wire
